// file: src/npch_param_info.sv
// npch_param_info: per-identifier value length and reset-dependence lookup.
// Purely combinational; unknown identifiers report known low and zero length.
`timescale 1ns/1ps
`default_nettype none

module npch_param_info (
  // lookup
  input  wire logic [7:0] id,
  // answer
  output logic            known,
  output logic [3:0]      len,
  output logic            needs_reset
);

  always_comb begin
    known       = (id <= npch_pkg::LAST_PARAM_ID);
    len         = npch_pkg::LEN_SHORT;
    needs_reset = 1'b1;
    case (id)
      8'h00, 8'h03, 8'h04, 8'h0f: len = npch_pkg::LEN_WORD;    // R10
      8'h0c, 8'h0d, 8'h0e: begin
        len         = npch_pkg::LEN_CONTEXT;                  // R10
        needs_reset = 1'b0;                                   // R11
      end
      8'h10: needs_reset = 1'b0;                              // R11
      default: begin
        if (!known) begin
          len         = 4'h0;
          needs_reset = 1'b0;
        end
      end
    endcase
  end

endmodule

`default_nettype wire

// file: src/npch_pkg.sv
// npch_pkg: shared constants and carrier types of the network parameter command handler.
// Assumes framing, checksums and transport are stripped before bytes reach the handler.
package npch_pkg;

  // command opcodes, first byte of each command
  localparam logic [7:0] CMD_GET_NET    = 8'h25;
  localparam logic [7:0] CMD_GET_CERT   = 8'h26;
  localparam logic [7:0] CMD_ACK_CTRL   = 8'h27;
  localparam logic [7:0] CMD_SET_PARAM  = 8'h28;
  localparam logic [7:0] CMD_GET_PARAM  = 8'h29;

  // response codes
  localparam logic [7:0] RC_OK          = 8'h00;
  localparam logic [7:0] RC_SHORT       = 8'h01;
  localparam logic [7:0] RC_LONG        = 8'h02;
  localparam logic [7:0] RC_BAD_ID      = 8'h03;

  // parameter table
  localparam int         NUM_PARAMS     = 17;
  localparam int         PARAM_W        = 64;
  localparam logic [7:0] LAST_PARAM_ID  = 8'h10;
  localparam logic [3:0] LEN_SHORT      = 4'h1;
  localparam logic [3:0] LEN_WORD       = 4'h2;
  localparam logic [3:0] LEN_CONTEXT    = 4'h8;
  localparam logic [7:0] NET_BLK_LEN    = 8'h0f;
  localparam logic [7:0] ACK_EN_RST     = 8'h00;

  // register port
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h1;
  localparam logic [3:0] REG_PENDING    = 4'h2;
  localparam int         CTRL_NETRST    = 0;
  localparam int         STAT_ACK_EN    = 0;
  localparam int         STAT_BUSY      = 1;

  typedef enum logic [1:0] {
    NPCH_IDLE = 2'b00,
    NPCH_RECV = 2'b01,
    NPCH_EXEC = 2'b11,
    NPCH_RESP = 2'b10
  } npch_fsm_type;

  typedef enum logic [1:0] {
    NPCH_K_CODE  = 2'b00,
    NPCH_K_PARAM = 2'b01,
    NPCH_K_NET   = 2'b10,
    NPCH_K_CERT  = 2'b11
  } npch_kind_type;

  typedef struct packed {
    logic       first;
    logic       last;
    logic [7:0] data;
  } npch_in_type;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } npch_out_type;

  typedef struct packed {
    npch_fsm_type                           fsm;
    logic [7:0]                             op;
    logic [7:0]                             cnt;
    logic [7:0]                             sel;
    logic [PARAM_W-1:0]                     val;
    logic                                   ack_en;
    npch_kind_type                          kind;
    logic [7:0]                             idx;
    logic [7:0]                             nbytes;
    logic [NUM_PARAMS-1:0]                  pend;
    logic [NUM_PARAMS-1:0][PARAM_W-1:0]     act;
    logic [NUM_PARAMS-1:0][PARAM_W-1:0]     pnd;
    logic                                   in_ready;
    logic                                   out_valid;
    npch_out_type                           out;
    logic [31:0]                            rdata;
  } npch_state_type;

endpackage

// file: src/npch_top.sv
// npch_top: command interpreter for network configuration, certification id,
// acknowledge control and single-parameter set/get.
// Assumes a deframed byte stream in, a byte stream out, and a plain register port.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: get-config ignores arguments, answers code 0 plus 15-byte config block.
// R2: get-certification ignores arguments, answers code 0 plus ASCII id string.
// R3: acknowledgements are off after reset.
// R4: success-only replies go out only while acknowledgements are enabled.
// R5: ack-control byte zero disables, any nonzero value enables.
// R6: ack-control always answers 0, except disabling while already disabled; the code answers 1 when no value byte follows.
// R7: host sends set-parameter as selector byte then value of matching length.
// R8: set-parameter answers 0 ok, 1 short, 2 long, 3 unknown selector.
// R9: reset-dependent writes stay pending; queries show old value until network reset.
// R10: ids 0,3,4,15 two bytes; 12-14 eight bytes; rest one byte.
// R11: ids 12-14 and 16 act at once; all others need network reset.
// R12: get-parameter answers 0 plus active value, 1 short, 3 unknown.
// R13: get-parameter drops bytes beyond the selector silently.
// R14: keep pending and active copies; network reset copies pending to active.
module npch_top #(
  parameter int          CERT_LEN = 12,
  // arbitrary neutral identifier text
  parameter logic [95:0] CERT_STR = 96'h4345_5254_2d49_442d_3030_3030
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // command bytes in
  input  wire logic                  in_valid,
  input  wire npch_pkg::npch_in_type in_byte,
  output logic                       in_ready,
  // response bytes out
  output logic                       out_valid,
  output npch_pkg::npch_out_type     out_byte,
  input  wire logic                  out_ready,
  // register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata
);

  localparam int NP = npch_pkg::NUM_PARAMS;

  logic [1:0]                 rst_sync_q;
  logic                       rst_sync_n;
  npch_pkg::npch_state_type   s_q;
  npch_pkg::npch_state_type   s_d;
  logic                       sel_known;
  logic [3:0]                 sel_len;
  logic                       sel_needs_reset;
  logic [NP-1:0]              needs_reset_vec;
  logic [119:0]               net_blk;
  logic                       in_take;
  logic                       out_take;
  logic                       net_reset;

  // release reset through two flops so every state flop leaves reset together
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_q[1];

  npch_param_info u_sel_info (
    .id          (s_q.sel),
    .known       (sel_known),
    .len         (sel_len),
    .needs_reset (sel_needs_reset)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_info
      npch_param_info u_info (
        .id          (8'(gi)),
        .known       (),
        .len         (),
        .needs_reset (needs_reset_vec[gi])
      );
    end
  endgenerate

  // configuration block from active values, ids 0 to 11 in order
  assign net_blk = {s_q.act[0][15:0], s_q.act[1][7:0], s_q.act[2][7:0],
                    s_q.act[3][15:0], s_q.act[4][15:0], s_q.act[5][7:0],
                    s_q.act[6][7:0], s_q.act[7][7:0], s_q.act[8][7:0],
                    s_q.act[9][7:0], s_q.act[10][7:0], s_q.act[11][7:0]}; // R1

  assign in_take   = in_valid & s_q.in_ready;
  assign out_take  = s_q.out_valid & out_ready;
  assign net_reset = reg_wr & (reg_addr == npch_pkg::REG_CTRL) &
                     reg_wdata[npch_pkg::CTRL_NETRST];

  // byte i of the response under construction, most significant value byte first
  function automatic logic [7:0] resp_byte(
    input npch_pkg::npch_state_type st,
    input logic [7:0]               i,
    input logic [3:0]               plen,
    input logic [119:0]             blk,
    input logic [7:0]               code
  );
    logic [63:0]  v;
    logic [7:0]   sh;
    logic [4:0]   sidx;
    v    = 64'h0000_0000_0000_0000;
    sh   = 8'h00;
    sidx = st.sel[4:0];
    if (i == 8'h00) begin
      resp_byte = code;
    end else begin
      case (st.kind)
        npch_pkg::NPCH_K_PARAM: begin
          if (int'(sidx) < NP) begin
            v = st.act[sidx];                                 // R12
          end
          sh        = {4'h0, plen} - i;
          resp_byte = 8'(v >> {sh, 3'b000});
        end
        npch_pkg::NPCH_K_NET: begin
          sh        = npch_pkg::NET_BLK_LEN - i;
          resp_byte = 8'(blk >> {sh, 3'b000});
        end
        npch_pkg::NPCH_K_CERT: begin
          sh        = 8'(CERT_LEN) - i;
          resp_byte = 8'(CERT_STR >> {sh, 3'b000});
        end
        default: resp_byte = 8'h00;
      endcase
    end
  endfunction

  always_comb begin
    logic       reply;
    logic [7:0] code;
    logic [7:0] need;
    logic [7:0] nxt;
    s_d   = s_q;
    reply = 1'b0;
    code  = npch_pkg::RC_OK;
    need  = 8'h00;
    nxt   = 8'h00;

    case (s_q.fsm)
      npch_pkg::NPCH_IDLE: begin
        if (in_take && in_byte.first) begin
          s_d.op  = in_byte.data;
          s_d.cnt = 8'h00;
          s_d.val = '0;
          s_d.sel = 8'h00;
          s_d.fsm = in_byte.last ? npch_pkg::NPCH_EXEC : npch_pkg::NPCH_RECV;
        end
      end
      npch_pkg::NPCH_RECV: begin
        if (in_take) begin
          if (s_q.cnt == 8'h00) begin
            s_d.sel = in_byte.data;
          end else begin
            s_d.val = {s_q.val[55:0], in_byte.data};
          end
          // saturate so an overlong frame still reads as too long
          if (s_q.cnt != 8'hff) begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
          if (in_byte.last) begin
            s_d.fsm = npch_pkg::NPCH_EXEC;
          end
        end
      end
      npch_pkg::NPCH_EXEC: begin
        s_d.kind   = npch_pkg::NPCH_K_CODE;
        s_d.nbytes = 8'h01;
        case (s_q.op)
          npch_pkg::CMD_GET_NET: begin
            reply      = 1'b1;                                // R1
            s_d.kind   = npch_pkg::NPCH_K_NET;
            s_d.nbytes = npch_pkg::NET_BLK_LEN + 8'h01;
          end
          npch_pkg::CMD_GET_CERT: begin
            reply      = 1'b1;                                // R2
            s_d.kind   = npch_pkg::NPCH_K_CERT;
            s_d.nbytes = 8'(CERT_LEN + 1);
          end
          npch_pkg::CMD_ACK_CTRL: begin
            if (s_q.cnt == 8'h00) begin
              reply = 1'b1;
              code  = npch_pkg::RC_SHORT;
            end else begin
              s_d.ack_en = (s_q.sel != 8'h00);                // R5
              reply      = (s_q.sel != 8'h00) || s_q.ack_en;  // R6
            end
          end
          npch_pkg::CMD_SET_PARAM: begin
            need = {4'h0, sel_len} + 8'h01;                   // R7
            if (s_q.cnt == 8'h00) begin
              reply = 1'b1;
              code  = npch_pkg::RC_SHORT;                     // R8
            end else if (!sel_known) begin
              reply = 1'b1;
              code  = npch_pkg::RC_BAD_ID;                    // R8
            end else if (s_q.cnt < need) begin
              reply = 1'b1;
              code  = npch_pkg::RC_SHORT;                     // R8
            end else if (s_q.cnt > need) begin
              reply = 1'b1;
              code  = npch_pkg::RC_LONG;                      // R8
            end else begin
              reply = s_q.ack_en;                             // R4
              s_d.pnd[s_q.sel[4:0]] = s_q.val;                // R14
              if (sel_needs_reset) begin
                s_d.pend[s_q.sel[4:0]] = 1'b1;                // R9
              end else begin
                s_d.act[s_q.sel[4:0]] = s_q.val;              // R11
              end
            end
          end
          npch_pkg::CMD_GET_PARAM: begin
            reply = 1'b1;
            if (s_q.cnt == 8'h00) begin
              code = npch_pkg::RC_SHORT;                      // R12
            end else if (!sel_known) begin
              code = npch_pkg::RC_BAD_ID;                     // R12
            end else begin
              // trailing bytes were counted but play no part here
              s_d.kind   = npch_pkg::NPCH_K_PARAM;            // R13
              s_d.nbytes = {4'h0, sel_len} + 8'h01;
            end
          end
          default: reply = 1'b0;
        endcase
        if (reply) begin
          s_d.idx       = 8'h00;
          s_d.out_valid = 1'b1;
          s_d.out.data  = code;
          s_d.out.last  = (s_d.nbytes == 8'h01);
          s_d.fsm       = npch_pkg::NPCH_RESP;
        end else begin
          s_d.fsm       = npch_pkg::NPCH_IDLE;
        end
      end
      npch_pkg::NPCH_RESP: begin
        if (out_take) begin
          if (s_q.out.last) begin
            s_d.out_valid = 1'b0;
            s_d.out.last  = 1'b0;
            s_d.fsm       = npch_pkg::NPCH_IDLE;
          end else begin
            nxt          = s_q.idx + 8'h01;
            s_d.idx      = nxt;
            s_d.out.data = resp_byte(s_q, nxt, sel_len, net_blk, npch_pkg::RC_OK);
            s_d.out.last = (nxt + 8'h01 == s_q.nbytes);
          end
        end
      end
      default: s_d.fsm = npch_pkg::NPCH_IDLE;
    endcase

    // network reset promotes every pending value at once
    if (net_reset) begin
      for (int k = 0; k < NP; k++) begin
        if (needs_reset_vec[k] && s_d.pend[k]) begin
          s_d.act[k]  = s_d.pnd[k];                           // R14
          s_d.pend[k] = 1'b0;                                 // R9
        end
      end
    end

    s_d.in_ready = (s_d.fsm == npch_pkg::NPCH_IDLE) ||
                   (s_d.fsm == npch_pkg::NPCH_RECV);

    s_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        npch_pkg::REG_STATUS: begin
          s_d.rdata[npch_pkg::STAT_ACK_EN] = s_q.ack_en;
          s_d.rdata[npch_pkg::STAT_BUSY]   = (s_q.fsm != npch_pkg::NPCH_IDLE);
        end
        npch_pkg::REG_PENDING: s_d.rdata[NP-1:0] = s_q.pend;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q          <= '0;
      s_q.fsm      <= npch_pkg::NPCH_IDLE;
      s_q.ack_en   <= npch_pkg::ACK_EN_RST[0];                // R3
      s_q.in_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready  = s_q.in_ready;
  assign out_valid = s_q.out_valid;
  assign out_byte  = s_q.out;
  assign reg_rdata = s_q.rdata;

endmodule

`default_nettype wire

// file: verif/npch_chk.sv
// npch_chk: port-level assertions for the command handler.
// Assumes one command at a time with honest first/last marks.
`timescale 1ns/1ps
`default_nettype none

module npch_chk (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rst_n,
  // command bytes
  input wire logic                   in_valid,
  input wire npch_pkg::npch_in_type  in_byte,
  input wire logic                   in_ready,
  // response bytes
  input wire logic                   out_valid,
  input wire npch_pkg::npch_out_type out_byte,
  input wire logic                   out_ready,
  // register port
  input wire logic [3:0]             reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata
);
  logic [7:0] op_q, cnt_q, sel_q, op, cnt, sel;
  logic       ack_q, fin;
  assign op  = in_byte.first ? in_byte.data : op_q;
  assign cnt = in_byte.first ? 8'h00 : cnt_q;
  assign sel = (cnt == 8'h01) ? in_byte.data : sel_q;
  assign fin = in_valid && in_ready && in_byte.last;
  // shadow of the framing, so each reply can be tied to its command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_q  <= 8'h00;
      cnt_q <= 8'h00;
      sel_q <= 8'h00;
      ack_q <= 1'b0;
    end else if (in_valid && in_ready) begin
      op_q  <= op;
      cnt_q <= cnt + 8'h01;
      sel_q <= sel;
      if (op == npch_pkg::CMD_ACK_CTRL && cnt == 8'h01) begin
        ack_q <= in_byte.data != 8'h00;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence code_s(logic [7:0] c);
    ##[1:3] out_valid && out_byte.data == c;
  endsequence

  net_reply_a: assert property (fin && op == npch_pkg::CMD_GET_NET |-> code_s(8'h00))
    else $error("config request without code zero");
  cert_reply_a: assert property (fin && op == npch_pkg::CMD_GET_CERT |-> code_s(8'h00))
    else $error("identifier request without code zero");
  ack_reply_a: assert property (fin && op == npch_pkg::CMD_ACK_CTRL && cnt == 8'h01
    && (in_byte.data != 8'h00 || ack_q) |-> code_s(8'h00)) else $error("ack control unanswered");
  ack_silent_a: assert property (fin && op == npch_pkg::CMD_ACK_CTRL && cnt == 8'h01
    && in_byte.data == 8'h00 && !ack_q |-> ##1 !out_valid [*3]) else $error("spurious reply");
  get_short_a: assert property (fin && op == npch_pkg::CMD_GET_PARAM && cnt == 8'h00
    |-> code_s(npch_pkg::RC_SHORT)) else $error("short query not code one");
  get_bad_id_a: assert property (fin && op == npch_pkg::CMD_GET_PARAM && cnt != 8'h00
    && sel > 8'h10 |-> code_s(npch_pkg::RC_BAD_ID)) else $error("bad query id not code three");
  set_short_a: assert property (fin && op == npch_pkg::CMD_SET_PARAM && cnt == 8'h00
    |-> code_s(npch_pkg::RC_SHORT)) else $error("short set not code one");
  set_bad_id_a: assert property (fin && op == npch_pkg::CMD_SET_PARAM && cnt != 8'h00
    && sel > 8'h10 |-> code_s(npch_pkg::RC_BAD_ID)) else $error("bad set id not code three");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("response byte dropped before taken");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule

bind npch_top npch_chk i_npch_chk (.mclk, .rst_n, .in_valid, .in_byte, .in_ready, .out_valid,
  .out_byte, .out_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
`default_nettype wire

// file: verif/npch_host.sv
// npch_host: host-side model that sends whole commands and gathers replies.
// Assumes send is called just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module npch_host (
  // clock
  input  wire logic                   mclk,
  // command bytes
  output logic                        in_valid,
  output npch_pkg::npch_in_type       in_byte,
  input  wire logic                   in_ready,
  // response bytes
  input  wire logic                   out_valid,
  input  wire npch_pkg::npch_out_type out_byte,
  output logic                        out_ready
);
  logic [8:0] rsp[$];
  bit         slow;
  initial begin
    in_valid  = 1'b0;
    in_byte   = '0;
    out_ready = 1'b1;
  end
  // slow mode stalls the reply stream at random
  always @(posedge mclk) begin
    if (out_valid && out_ready) rsp.push_back({out_byte.last, out_byte.data});
    out_ready <= !slow || $urandom_range(1);
  end
  // opcode, selector then value, each byte held until taken
  task automatic send(input logic [7:0] c[$]);
    @(posedge mclk);
    for (int k = 0; k < c.size(); k++) begin
      in_valid <= 1'b1;
      in_byte  <= '{k == 0, k == c.size() - 1, c[k]};
      do @(posedge mclk); while (in_ready !== 1'b1);
    end
    in_valid     <= 1'b0;
    in_byte.data <= ~c[c.size() - 1];
  endtask
endmodule
`default_nettype wire

// file: verif/npch_top_test.sv
// npch_top_test: self-checking bench with a byte-level reference model.
// Assumes npch_host as the far side and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module npch_top_test;
  localparam logic [7:0] SETP = npch_pkg::CMD_SET_PARAM;
  localparam logic [7:0] GETP = npch_pkg::CMD_GET_PARAM;
  localparam logic [7:0] ACKC = npch_pkg::CMD_ACK_CTRL;
  // arbitrary twelve-character text
  localparam logic [95:0] CERT = 96'h5445_5354_2d43_4552_542d_3031;
  logic                   mclk = 1'b0;
  logic                   rst_n;
  logic                   in_valid, in_ready, out_valid, out_ready;
  npch_pkg::npch_in_type  in_byte;
  npch_pkg::npch_out_type out_byte;
  logic [3:0]             reg_addr;
  logic [31:0]            reg_wdata;
  logic [31:0]            reg_rdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [63:0]            act[17] = '{default: 64'h0};
  logic [63:0]            pnd[17] = '{default: 64'h0};
  bit                     pend[17];
  bit                     ack;
  logic [7:0]             e[$];
  int                     miscompares, num_checks;

  always #5 mclk = ~mclk;

  npch_top #(.CERT_LEN(12), .CERT_STR(CERT)) i_npch_top (.mclk, .rst_n, .in_valid, .in_byte,
    .in_ready, .out_valid, .out_byte, .out_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  npch_host i_npch_host (.mclk, .in_valid, .in_byte, .in_ready, .out_valid, .out_byte,
    .out_ready);

  task automatic summarize;
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string s, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", s, ex, got);
    end
  endtask

  task automatic reg_rw(input bit wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= wr;
    reg_rd    <= !wr;
    reg_addr  <= a;
    // write data bus carries noise during reads so the slave cannot lean on it
    reg_wdata <= wr ? d : 32'($urandom);
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!wr) check("reg_rdata", d, reg_rdata);
  endtask

  function automatic int plen(int id);
    if (id == 0 || id == 3 || id == 4 || id == 15) return 2;
    if (id >= 12 && id <= 14) return 8;
    return 1;
  endfunction

  task automatic put(logic [63:0] v, int l);
    for (int j = l - 1; j >= 0; j--) e.push_back(v[8*j+:8]);
  endtask

  task automatic run(input logic [7:0] c[$]);
    int          id, n, k;
    logic [63:0] v;
    id = c.size() > 1 ? int'(c[1]) : -1;
    n  = c.size() - 2;
    case (c[0])
      npch_pkg::CMD_GET_NET: begin
        e.push_back(8'h00);
        for (k = 0; k < 12; k++) put(act[k], plen(k));
      end
      npch_pkg::CMD_GET_CERT: begin
        e.push_back(8'h00);
        put(CERT[95:32], 8);
        put(CERT[31:0], 4);
      end
      ACKC: if (id < 0) e.push_back(8'h01);
      else begin
        if (id != 0 || ack) e.push_back(8'h00);
        ack = id != 0;
      end
      SETP: if (id < 0 || (id <= 16 && n < plen(id))) e.push_back(8'h01);
      else if (id > 16) e.push_back(8'h03);
      else if (n > plen(id)) e.push_back(8'h02);
      else begin
        v = 64'h0;
        for (k = 2; k < c.size(); k++) v = {v[55:0], c[k]};
        if (id < 12 || id == 15) begin
          pnd[id]  = v;
          pend[id] = 1'b1;
        end else act[id] = v;
        if (ack) e.push_back(8'h00);
      end
      default: if (id < 0) e.push_back(8'h01);
      else if (id > 16) e.push_back(8'h03);
      else begin
        e.push_back(8'h00);
        put(act[id], plen(id));
      end
    endcase
    i_npch_host.send(c);
    #1;
    for (k = 0; k < 400 && in_ready !== 1'b1; k++) @(posedge mclk) #1;
    check("in_ready", 1, in_ready);
    check("reply length", e.size(), i_npch_host.rsp.size());
    foreach (e[j]) if (j < i_npch_host.rsp.size())
      check("reply byte", {j == e.size() - 1, e[j]}, i_npch_host.rsp[j]);
    i_npch_host.rsp.delete();
    e.delete();
  endtask

  task automatic cmd(input logic [7:0] op, input int id, input int n);
    logic [7:0] c[$];
    c.push_back(op);
    if (id >= 0) c.push_back(id[7:0]);
    repeat (n) c.push_back(8'($urandom));
    run(c);
  endtask

  function automatic logic [31:0] pmask();
    pmask = 32'h0;
    for (int k = 0; k < 17; k++) pmask[k] = pend[k];
  endfunction

  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    summarize();
  end

  initial begin
    int k;
    rst_n     = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    void'($urandom(32'h1fd5_27a0));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    reg_rw(0, npch_pkg::REG_STATUS, 32'h0);
    reg_rw(0, 4'hf, 32'h0);
    cmd(SETP, 12, 8);
    cmd(GETP, 12, 0);
    cmd(ACKC, 0, 0);
    cmd(ACKC, -1, 0);
    cmd(ACKC, 1 + $urandom_range(254), 0);
    reg_rw(0, npch_pkg::REG_STATUS, 32'h1);
    for (k = 0; k < 18; k++) begin
      cmd(SETP, k, plen(k));
      cmd(GETP, k, k % 3);
    end
    // writes without the reset bit, or to other addresses, must leave values pending
    reg_rw(1, npch_pkg::REG_CTRL, 32'($urandom) & 32'hffff_fffe);
    reg_rw(1, npch_pkg::REG_STATUS, 32'($urandom));
    reg_rw(0, npch_pkg::REG_STATUS, 32'h1);
    reg_rw(0, npch_pkg::REG_PENDING, pmask());
    reg_rw(1, npch_pkg::REG_CTRL, 32'($urandom) | 32'h1);
    reg_rw(0, npch_pkg::REG_PENDING, 32'h0);
    for (k = 0; k < 17; k++) if (pend[k]) begin
      act[k]  = pnd[k];
      pend[k] = 1'b0;
    end
    i_npch_host.slow = 1'b1;
    for (k = 0; k < 17; k++) cmd(GETP, k, 0);
    cmd(npch_pkg::CMD_GET_NET, $urandom_range(255), 2);
    cmd(npch_pkg::CMD_GET_CERT, -1, 3);
    cmd(SETP, 0, 1);
    cmd(SETP, 4, 3);
    cmd(SETP, 200, 2);
    cmd(SETP, -1, 0);
    cmd(GETP, -1, 0);
    cmd(SETP, 16, 1);
    cmd(GETP, 16, 0);
    cmd(ACKC, 0, 0);
    cmd(ACKC, 0, 0);
    cmd(SETP, 3, 2);
    summarize();
  end
endmodule
`default_nettype wire
